// File: core/security_lock.v
// device security lock: key latch, sampled lock, flash command gating
// assumes a host drives requests one at a time, synchronous to mclk_i
`timescale 1ns/100ps
`include "security_lock_defines.vh"

module security_lock #(
  parameter NUM_BLOCKS = `NUM_BLOCKS,
  parameter [7:0] COMMIT_CYCLES = `COMMIT_CYCLES
) (
  input wire mclk_i,
  input wire reset_i,
  input wire key_load_i,
  input wire [`KEY_WIDTH-1:0] key_data_i,
  input wire key_commit_i,
  input wire cmd_valid_i,
  input wire [2:0] cmd_i,
  input wire [`BLOCK_IDX_WIDTH-1:0] cmd_block_i,
  input wire [`PROT_WIDTH-1:0] cmd_prot_i,
  input wire [NUM_BLOCKS-1:0] block_allow_i,
  input wire latch_read_i,
  input wire debug_req_i,
  input wire test_req_i,
  output reg debug_en_o,
  output reg test_en_o,
  output reg prog_en_o,
  output reg secured_o,
  output reg key_busy_o,
  output reg key_done_o,
  output reg key_reject_o,
  output reg cmd_done_o,
  output reg cmd_reject_o,
  output reg [2:0] flash_op_o,
  output reg [`BLOCK_IDX_WIDTH-1:0] flash_block_o,
  output reg [`PROT_WIDTH-1:0] prot_level_o,
  output reg [`KEY_WIDTH-1:0] latch_rdata_o,
  output reg latch_rvalid_o
);

  localparam ST_IDLE = 2'h0;
  localparam ST_COMMIT = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] count_q;
  reg [7:0] count_d;
  reg in_reset_q;
  reg lock_q;
  reg [`PROT_WIDTH-1:0] prot_q;
  reg staged_q;
  wire [`KEY_WIDTH-1:0] cells;
  wire wrapper_out;
  wire commit_pulse;
  wire key_ok;
  wire load_ok;
  wire gate_open;
  wire commit_ok;
  wire cmd_legal;
  reg lock_d;
  reg [`PROT_WIDTH-1:0] prot_d;
  reg debug_en_d;
  reg test_en_d;
  reg prog_en_d;
  reg cmd_done_d;
  reg cmd_reject_d;
  reg [2:0] flash_op_d;
  reg [`BLOCK_IDX_WIDTH-1:0] flash_block_d;
  reg [`KEY_WIDTH-1:0] latch_rdata_d;

  // ==========================================
  // latch storage and majority wrapper
  // key only without flash protection
  assign key_ok = (prot_q == `PROT_NONE);
  // no change once wrapper output is high
  assign load_ok = key_load_i && key_ok && !wrapper_out && !lock_q;
  assign commit_pulse = (state_q == ST_COMMIT) && (count_q == 8'h1);
  // closed until the sampled lock is known
  // the first edge after release still sees lock_q low
  assign gate_open = !lock_q && !in_reset_q;
  // commit needs a staged, unprotected, unfrozen key
  assign commit_ok = staged_q && key_ok && !wrapper_out;

  latch_cells #(
    .WIDTH(`KEY_WIDTH)
  ) u_cells (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .load_i(load_ok),
    .load_data_i(key_data_i),
    .commit_i(commit_pulse),
    .frozen_i(wrapper_out),
    .cells_o(cells)
  );

  majority_match #(
    .WIDTH(`KEY_WIDTH)
  ) u_match (
    .cells_i(cells),
    .pattern_i(`KEY_SIGNATURE),
    .min_i(`MATCH_MIN),
    .match_o(wrapper_out)
  );

  // ==========================================
  // lock sampling
  // sample only while in reset, then hold
  // captured on the first edge after release
  always @(posedge mclk_i) begin
    if (reset_i) begin
      in_reset_q <= 1'b1;
    end else begin
      in_reset_q <= 1'b0;
    end
  end

  // lock follows commit only through a reset
  // a fresh commit leaves lock_q alone until reset
  always @* begin
    lock_d = lock_q;
    if (in_reset_q) begin
      lock_d = wrapper_out;
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
    end
  end

  // ==========================================
  // key commit sequence
  always @* begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      ST_IDLE: begin
        if (key_commit_i && commit_ok) begin
          state_d = ST_COMMIT;
          count_d = COMMIT_CYCLES;
        end
      end
      ST_COMMIT: begin
        count_d = count_q - 8'h1;
        if (count_q == 8'h1) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      state_q <= ST_IDLE;
      count_q <= 8'h0;
      staged_q <= 1'b0;
      key_done_o <= 1'b0;
      key_reject_o <= 1'b0;
      key_busy_o <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      if (load_ok) begin
        staged_q <= 1'b1;
      end
      key_busy_o <= (state_d == ST_COMMIT);
      key_done_o <= (state_d == ST_DONE);
      key_reject_o <= (key_load_i && !load_ok) ||
        (key_commit_i && state_q == ST_IDLE && !commit_ok);
    end
  end

  // ==========================================
  // flash protection and command gating
  // protection level is nonvolatile: survives reset
  initial prot_q = `PROT_NONE;

  // clear only on full device erase
  // a locked part takes no protection change
  always @* begin
    prot_d = prot_q;
    if (!reset_i && cmd_legal) begin
      case (cmd_i)
        `CMD_FULL_ERASE: begin
          prot_d = `PROT_NONE;
        end
        `CMD_SET_PROT: begin
          // raise only: a lower level never weakens protection
          if (cmd_prot_i > prot_q) begin
            prot_d = cmd_prot_i;
          end
        end
        default: begin
          prot_d = prot_q;
        end
      endcase
    end
  end

  // nonvolatile: no reset term, the level outlives reset
  always @(posedge mclk_i) begin
    prot_q <= prot_d;
  end

  function block_op_ok;
    input [2:0] op;
    input [NUM_BLOCKS-1:0] allow;
    input [`BLOCK_IDX_WIDTH-1:0] idx;
    begin
      block_op_ok = 1'b1;
      if (op == `CMD_BLOCK_ERASE || op == `CMD_BLOCK_PROG ||
          op == `CMD_BLOCK_VERIFY) begin
        block_op_ok = allow[idx];
      end
    end
  endfunction

  assign cmd_legal = cmd_valid_i && gate_open && (cmd_i != `CMD_NONE) &&
    (cmd_i <= `CMD_SET_PROT) &&
    block_op_ok(cmd_i, block_allow_i, cmd_block_i);

  // refused ops leave the block index alone
  always @* begin
    cmd_done_d = cmd_legal;
    cmd_reject_d = cmd_valid_i && !cmd_legal;
    flash_op_d = `CMD_NONE;
    flash_block_d = flash_block_o;
    if (cmd_legal) begin
      flash_op_d = cmd_i;
      flash_block_d = cmd_block_i;
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      cmd_done_o <= 1'b0;
      cmd_reject_o <= 1'b0;
      flash_op_o <= `CMD_NONE;
      flash_block_o <= {`BLOCK_IDX_WIDTH{1'b0}};
      prot_level_o <= `PROT_NONE;
    end else begin
      cmd_done_o <= cmd_done_d;
      cmd_reject_o <= cmd_reject_d;
      flash_op_o <= flash_op_d;
      flash_block_o <= flash_block_d;
      prot_level_o <= prot_q;
    end
  end

  // ==========================================
  // port enables and latch readout
  // debug and test shut while locked
  // enables stay low until reset resamples
  always @* begin
    debug_en_d = debug_req_i && gate_open;
    test_en_d = test_req_i && gate_open;
    prog_en_d = gate_open;
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      debug_en_o <= 1'b0;
      test_en_o <= 1'b0;
      prog_en_o <= 1'b0;
      secured_o <= 1'b0;
    end else begin
      debug_en_o <= debug_en_d;
      test_en_o <= test_en_d;
      prog_en_o <= prog_en_d;
      secured_o <= lock_q;
    end
  end

  // contents readable over the debug port
  // reads stay open when locked so protected parts can be told apart
  always @* begin
    latch_rdata_d = latch_rdata_o;
    if (latch_read_i) begin
      latch_rdata_d = cells;
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      latch_rdata_o <= {`KEY_WIDTH{1'b0}};
      latch_rvalid_o <= 1'b0;
    end else begin
      latch_rvalid_o <= latch_read_i;
      latch_rdata_o <= latch_rdata_d;
    end
  end

endmodule // security_lock

// File: core/security_lock_defines.vh
// constants for the device security lock latch block
// assumes a single 10 MHz clock and synchronous active-high reset
//
// Function
// - the latch holds four key bytes, 32 bits compared as one unit.
// - the wrapper output is high when 28 or more of 32 bits match.
// - while the sampled latch output is high, debug and test are shut.
// - once secured, test, programming and debug ports stay disabled.
// - while the latch output is high, erase or change of it is refused.
// - the latch output is sampled only in reset and held until the next.
// - locking needs key load, commit to nonvolatile cells, then reset.
// - a key write is accepted only while no flash protection is set.
// - after a key write, port access stays until the next reset.
// - the latch contents can be read over the serial wire debug port.
// - flash protection clears only as part of a full device erase.
// - per-block erase, program, verify only where block security allows.
`ifndef SECURITY_LOCK_DEFINES_VH
`define SECURITY_LOCK_DEFINES_VH

`define KEY_WIDTH 32
// signature value is arbitrary
`define KEY_SIGNATURE 32'h5a3c_96e1
`define MATCH_MIN 6'd28
`define PROT_WIDTH 2
`define PROT_NONE 2'h0
`define BLOCK_IDX_WIDTH 4
`define NUM_BLOCKS 16

// flash command codes
`define CMD_NONE 3'h0
`define CMD_BLOCK_ERASE 3'h1
`define CMD_BLOCK_PROG 3'h2
`define CMD_BLOCK_VERIFY 3'h3
`define CMD_FULL_ERASE 3'h4
`define CMD_SET_PROT 3'h5

// latch commit length in clock cycles
`define COMMIT_CYCLES 8'd20

`endif

// File: core/majority_match.v
// popcount of matching key bits against the signature
// assumes purely combinational use from the nonvolatile cells
`timescale 1ns/100ps
`include "security_lock_defines.vh"

module majority_match #(
  parameter WIDTH = `KEY_WIDTH
) (
  input wire [WIDTH-1:0] cells_i,
  input wire [WIDTH-1:0] pattern_i,
  input wire [5:0] min_i,
  output wire match_o
);

  // ==========================================
  // bit agreement count
  function [5:0] count_ones;
    input [WIDTH-1:0] v;
    integer k;
    begin
      count_ones = 6'h0;
      for (k = 0; k < WIDTH; k = k + 1) begin
        count_ones = count_ones + {5'h0, v[k]};
      end
    end
  endfunction

  wire [5:0] agree;

  assign agree = count_ones(~(cells_i ^ pattern_i));
  assign match_o = (agree >= min_i);

endmodule // majority_match

// File: core/latch_cells.v
// latch frozen once matched: volatile stage plus nonvolatile cells
// assumes commit_i is a one-cycle pulse from the controller
`timescale 1ns/100ps
`include "security_lock_defines.vh"

module latch_cells #(
  parameter WIDTH = `KEY_WIDTH,
  parameter [WIDTH-1:0] CELL_INIT = 32'h0
) (
  input wire mclk_i,
  input wire reset_i,
  input wire load_i,
  input wire [WIDTH-1:0] load_data_i,
  input wire commit_i,
  input wire frozen_i,
  output reg [WIDTH-1:0] cells_o
);

  reg [WIDTH-1:0] stage_q;

  // ==========================================
  // volatile stage and nonvolatile commit
  // cells model nonvolatile storage: not cleared by reset
  always @(posedge mclk_i) begin
    if (reset_i) begin
      stage_q <= {WIDTH{1'b0}};
    end else if (load_i && !frozen_i) begin
      stage_q <= load_data_i;
    end
  end

  initial cells_o = CELL_INIT;

  always @(posedge mclk_i) begin
    if (commit_i && !frozen_i) begin
      cells_o <= stage_q;
    end
  end

endmodule // latch_cells

// File: dv/lock_asserts.sv
// checker: port relations of the security lock block
// assumes bind onto security_lock, one clock, sync reset
`timescale 1ns/100ps
module lock_asserts #(parameter NUM_BLOCKS = 16) (
  input wire mclk_i,
  input wire reset_i,
  input wire key_load_i,
  input wire cmd_valid_i,
  input wire [2:0] cmd_i,
  input wire [3:0] cmd_block_i,
  input wire [NUM_BLOCKS-1:0] block_allow_i,
  input wire latch_read_i,
  input wire debug_req_i,
  input wire debug_en_o,
  input wire test_en_o,
  input wire prog_en_o,
  input wire secured_o,
  input wire key_reject_o,
  input wire cmd_done_o,
  input wire cmd_reject_o,
  input wire [2:0] flash_op_o,
  input wire [1:0] prot_level_o,
  input wire latch_rvalid_o
);
  // ==========================================
  // assertions
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_lock_shuts_ports: assert property (
    secured_o |-> !(debug_en_o || test_en_o || prog_en_o))
    else $error("port open while locked");
  a_lock_held: assert property (
    !$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3) |->
    $stable(secured_o))
    else $error("lock changed outside reset");
  a_locked_cmd_refused: assert property (
    secured_o && cmd_valid_i |=> cmd_reject_o && !cmd_done_o)
    else $error("command ran while locked");
  a_locked_key_refused: assert property (
    secured_o && key_load_i |=> key_reject_o)
    else $error("key load taken while locked");
  a_prot_key_refused: assert property (
    key_load_i |=> key_reject_o || prot_level_o == 2'h0)
    else $error("key load taken under protection");
  a_block_deny_op: assert property (
    cmd_valid_i && cmd_i >= 3'h1 && cmd_i <= 3'h3 &&
    !block_allow_i[cmd_block_i] |=> cmd_reject_o && flash_op_o == 3'h0)
    else $error("denied block op ran");
  a_erase_clears_prot: assert property (
    cmd_valid_i && cmd_i == 3'h4 && prog_en_o |-> ##[1:3]
    prot_level_o == 2'h0) else $error("erase left protection");
  a_read_answers: assert property (
    latch_read_i |=> latch_rvalid_o) else $error("latch read lost");
  a_open_when_clear: assert property (
    !secured_o && debug_req_i && !$past(reset_i) && !$past(reset_i, 2)
    |=> debug_en_o)
    else $error("debug shut while unlocked");
  cover property (secured_o && cmd_reject_o);
  cover property (key_reject_o);
  cover property (latch_rvalid_o && secured_o);
endmodule // lock_asserts

bind security_lock lock_asserts #(.NUM_BLOCKS(NUM_BLOCKS)) u_chk (
  .mclk_i, .reset_i, .key_load_i, .cmd_valid_i, .cmd_i, .cmd_block_i,
  .block_allow_i, .latch_read_i, .debug_req_i, .debug_en_o, .test_en_o,
  .prog_en_o, .secured_o, .key_reject_o, .cmd_done_o, .cmd_reject_o,
  .flash_op_o, .prot_level_o, .latch_rvalid_o);

// File: dv/lock_host.sv
// host model: drives key and flash requests toward the device
// assumes the device samples requests on mclk_i rising edges
`timescale 1ns/100ps
module lock_host (
  input wire mclk_i,
  output reg key_load_o,
  output reg [31:0] key_data_o,
  output reg key_commit_o,
  output reg cmd_valid_o,
  output reg [2:0] cmd_o,
  output reg [3:0] cmd_block_o,
  output reg [1:0] cmd_prot_o
);
  // ==========================================
  // requests
  initial begin
    {key_load_o, key_commit_o, cmd_valid_o} = 3'h0;
    {key_data_o, cmd_o, cmd_block_o, cmd_prot_o} = 41'h0;
  end
  task key_write(input [31:0] k);
    begin
      @(posedge mclk_i) {key_load_o, key_data_o} <= {1'b1, k};
      // released data shows the inverted key, not the old key
      @(posedge mclk_i) {key_load_o, key_data_o} <= {1'b0, ~k};
      key_commit_o <= 1'b1;
      @(posedge mclk_i) key_commit_o <= 1'b0;
    end
  endtask
  task flash_cmd(input [2:0] op, input [3:0] blk, input [1:0] pr);
    begin
      @(posedge mclk_i) {cmd_valid_o, cmd_o, cmd_block_o, cmd_prot_o} <=
        {1'b1, op, blk, pr};
      @(posedge mclk_i) {cmd_valid_o, cmd_o, cmd_block_o, cmd_prot_o} <=
        {1'b0, ~op, ~blk, ~pr};
    end
  endtask
endmodule // lock_host

// File: dv/tb.sv
// testbench: unlocked access, protection, near-match keys, locking
// assumes the lock sticks, so locking runs last
`timescale 1ns/100ps
`include "security_lock_defines.vh"
module tb;
  reg mclk_i = 1'b0;
  reg reset_i = 1'b1;
  reg [15:0] block_allow_i = 16'h0001;
  reg latch_read_i = 1'b0;
  reg debug_req_i = 1'b1;
  reg test_req_i = 1'b1;
  wire kl, kc, cv;
  wire [31:0] kd, rd;
  wire [2:0] op, fo;
  wire [3:0] blk, fb;
  wire [1:0] pr, prot;
  wire den, ten, pen, sec, busy, kdone, krej, cdone, crej, rv;
  integer err_total = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  reg [2:0] seen;
  localparam [31:0] SIG = `KEY_SIGNATURE;
  always #50 mclk_i = ~mclk_i;
  lock_host u_host (.mclk_i(mclk_i), .key_load_o(kl), .key_data_o(kd),
    .key_commit_o(kc), .cmd_valid_o(cv), .cmd_o(op), .cmd_block_o(blk),
    .cmd_prot_o(pr));
  security_lock #(.COMMIT_CYCLES(8'd2)) u_dut (.mclk_i(mclk_i),
    .reset_i(reset_i), .key_load_i(kl), .key_data_i(kd), .key_commit_i(kc),
    .cmd_valid_i(cv), .cmd_i(op), .cmd_block_i(blk), .cmd_prot_i(pr),
    .block_allow_i(block_allow_i), .latch_read_i(latch_read_i),
    .debug_req_i(debug_req_i), .test_req_i(test_req_i), .debug_en_o(den),
    .test_en_o(ten), .prog_en_o(pen), .secured_o(sec), .key_busy_o(busy),
    .key_done_o(kdone), .key_reject_o(krej), .cmd_done_o(cdone),
    .cmd_reject_o(crej), .flash_op_o(fo), .flash_block_o(fb),
    .prot_level_o(prot), .latch_rdata_o(rd), .latch_rvalid_o(rv));
  // ==========================================
  // helpers
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task tally_and_finish;
    begin
      if (err_total == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // a hang counts as a mismatch
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  task do_reset(input exp_sec);
    begin
      @(posedge mclk_i) reset_i <= 1'b1;
      repeat (10) @(posedge mclk_i);
      reset_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      chk("secured_o", exp_sec, sec);
      chk("debug_en_o", !exp_sec, den);
      chk("test_en_o", !exp_sec, ten);
      chk("prog_en_o", !exp_sec, pen);
    end
  endtask
  task run_cmd(input [2:0] c, input [3:0] b, input [1:0] p, input ok);
    reg d, r;
    integer i;
    begin
      {d, r, seen} = 5'h0;
      u_host.flash_cmd(c, b, p);
      for (i = 0; i < 3; i = i + 1) begin
        @(negedge mclk_i);
        {d, r, seen} = {d | cdone, r | crej, seen | fo};
      end
      chk("cmd_done_o", ok, d);
      chk("cmd_reject_o", !ok, r);
      if (ok) chk("flash_block_o", b, fb);
    end
  endtask
  task run_key(input [31:0] k, input ok);
    reg d, r, b;
    integer i;
    begin
      {d, r, b} = 3'h0;
      u_host.key_write(k);
      for (i = 0; i < 8; i = i + 1) begin
        @(negedge mclk_i);
        {d, r, b} = {d | kdone, r | krej, b | busy};
      end
      chk("key_done_o", ok, d);
      chk("key_busy_o", ok, b);
      chk("key_reject_o", !ok, r);
      chk("debug_en_o", !sec, den);
    end
  endtask
  task read_latch(input [31:0] e);
    begin
      @(posedge mclk_i) latch_read_i <= 1'b1;
      @(posedge mclk_i) latch_read_i <= 1'b0;
      @(negedge mclk_i);
      chk("latch_rvalid_o", 1, rv);
      chk("latch_rdata_o", e, rd);
    end
  endtask
  // ==========================================
  // scenarios
  task t_protect;
    integer c;
    begin
      // requests withdrawn: enables follow them down
      @(posedge mclk_i) {debug_req_i, test_req_i} <= 2'h0;
      repeat (2) @(negedge mclk_i);
      chk("debug_en_o", 0, den);
      chk("test_en_o", 0, ten);
      @(posedge mclk_i) {debug_req_i, test_req_i} <= 2'h3;
      run_cmd(3'h5, 4'h0, 2'h1, 1);
      chk("prot_level_o", 2'h1, prot);
      run_key(SIG, 0);
      run_cmd(3'h4, 4'h0, 2'h0, 1);
      chk("prot_level_o", 2'h0, prot);
      for (c = 1; c < 4; c = c + 1) begin
        run_cmd(c[2:0], 4'h1, 2'h0, 0);
        run_cmd(c[2:0], 4'h0, 2'h0, 1);
        chk("flash_op_o", c, seen);
      end
      run_cmd(3'h6, 4'h0, 2'h0, 0);
    end
  endtask
  task t_lock;
    begin
      // five bits off: 27 of 32 do not lock
      run_key(SIG ^ 32'h1f, 1);
      read_latch(SIG ^ 32'h1f);
      do_reset(0);
      // four bits off: 28 of 32 lock
      run_key(SIG ^ 32'hf, 1);
      do_reset(1);
      run_cmd(3'h4, 4'h0, 2'h0, 0);
      run_key(SIG, 0);
      read_latch(SIG ^ 32'hf);
      do_reset(1);
    end
  endtask
  initial begin
    do_reset(0);
    t_protect;
    t_lock;
    tally_and_finish;
  end
endmodule // tb
